// ===== logic/tcp_timer.sv
/*
 compare, one pulse and pwm timer with byte register port.
 assumes a cpu master with one-cycle strobes; pins are asynchronous.
*/
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"
module tcp_timer
    import tcp_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic [`TCP_ADDR_W-1:0] addr,
    input  wire logic [7:0]             wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [7:0]             rdata,
    input  wire logic                   cpu_irq_mask,
    input  wire logic                   capture_input_one,
    input  wire logic                   capture_input_two,
    input  wire logic                   ext_clk_pin,
    output logic      [1:0]             compare_output_pin,
    output logic      [1:0]             compare_pin_enable,
    output logic                        timer_irq
);
    tcp_bus_s  bus;
    tcp_mode_e mode;
    logic [7:0]  timer_control_one;
    logic [7:0]  timer_control_two;
    logic [15:0] counter_reg;
    logic [15:0] compare_value_reg [2];
    logic [15:0] compare_active_reg [2];
    logic [1:0]  compare_inhibit_reg;
    logic [1:0]  compare_match_flag;
    logic [1:0]  capture_flag;
    logic [1:0]  flag_armed_cmp_reg;
    logic [1:0]  flag_armed_cap_reg;
    logic [15:0] capture_value_reg [2];
    logic [7:0]  cap_lo_latch_reg [2];
    logic [1:0]  capture_inhibit_reg;
    logic [1:0]  pin_reg;
    logic [2:0]  sync1_reg;
    logic [2:0]  sync2_reg;
    logic [1:0]  cap_prev_reg;
    logic [1:0]  cap_edge;
    logic [15:0] counter_next;
    logic [1:0]  match;
    logic [1:0]  lo_access;
    logic [1:0]  cap_lo_access;
    logic        tick;
    logic        status_read;
    logic        trig_pulse;
    logic        period_end;
    logic [7:0]  rdata_next;

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // only pwm when both bits set one pulse by its bit
    assign mode = timer_control_two[`TCP_B_PWM] ? TCP_MODE_PWM :
                  (timer_control_two[`TCP_B_PULSE] ? TCP_MODE_PULSE : TCP_MODE_CMP);

    // pins are async; two flops before any logic reads them
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end
        else
        begin
            sync1_reg <= {ext_clk_pin, capture_input_two, capture_input_one};
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            cap_prev_reg <= 2'h0;
        else
            cap_prev_reg <= sync2_reg[1:0];
    end

    assign cap_edge[0] = timer_control_one[`TCP_B_EDGE1] ? (sync2_reg[0] & ~cap_prev_reg[0])
                                                        : (~sync2_reg[0] & cap_prev_reg[0]);
    assign cap_edge[1] = timer_control_two[`TCP_B_EDGE2] ? (sync2_reg[1] & ~cap_prev_reg[1])
                                                        : (~sync2_reg[1] & cap_prev_reg[1]);

    tcp_tick u_tick
    (
        .clock         (clock),
        .rst_n         (rst_n),
        .clk_sel       (timer_control_two[`TCP_B_CLK_HI:`TCP_B_CLK_LO]),
        .ext_edge_rise (timer_control_two[`TCP_B_EXT_EDGE]),
        .ext_clk       (sync2_reg[2]),
        .tick          (tick)
    );

    assign status_read = bus.rd && (bus.addr == `TCP_A_STATUS);
    assign lo_access[0] = (bus.rd || bus.wr) && (bus.addr == `TCP_A_CMP1_LO);
    assign lo_access[1] = (bus.rd || bus.wr) && (bus.addr == `TCP_A_CMP2_LO);
    assign cap_lo_access[0] = bus.rd && (bus.addr == `TCP_A_CAP1_LO);
    assign cap_lo_access[1] = bus.rd && (bus.addr == `TCP_A_CAP2_LO);
    assign trig_pulse = (mode == TCP_MODE_PULSE) && cap_edge[0];

    // compare on counter after the tick's increment
    assign counter_next = counter_reg + 16'h0001;
    assign match[0] = tick && !compare_inhibit_reg[0] && (counter_next == compare_active_reg[0]);
    assign match[1] = tick && !compare_inhibit_reg[1] && (counter_next == compare_active_reg[1]);
    assign period_end = (mode == TCP_MODE_PWM) && match[1];

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            counter_reg <= `TCP_CNT_RELOAD;
        else if (trig_pulse)
            counter_reg <= `TCP_CNT_RELOAD;
        else if (bus.wr && bus.addr == `TCP_A_CNT_LO)
            counter_reg <= `TCP_CNT_RELOAD;
        else if (period_end)
            counter_reg <= `TCP_CNT_RELOAD;
        else if (tick)
            counter_reg <= counter_next;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            timer_control_one <= `TCP_CTRL_RESET;
        else if (bus.wr && bus.addr == `TCP_A_CTRL_ONE)
            timer_control_one <= bus.wdata;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            timer_control_two <= `TCP_CTRL_RESET;
        else if (bus.wr && bus.addr == `TCP_A_CTRL_TWO)
            timer_control_two <= bus.wdata;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cmp
            localparam logic [`TCP_ADDR_W-1:0] A_HI = gi ? `TCP_A_CMP2_HI : `TCP_A_CMP1_HI;
            localparam logic [`TCP_ADDR_W-1:0] A_LO = gi ? `TCP_A_CMP2_LO : `TCP_A_CMP1_LO;
            logic set_cmp;
            logic set_cap;

            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    compare_value_reg[gi] <= `TCP_CMP_RESET;
                else if (bus.wr && bus.addr == A_HI)
                    compare_value_reg[gi][15:8] <= bus.wdata;
                else if (bus.wr && bus.addr == A_LO)
                    compare_value_reg[gi][7:0] <= bus.wdata;
            end

            // pwm holds the active copy until period end
            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    compare_active_reg[gi] <= `TCP_CMP_RESET;
                else if (mode != TCP_MODE_PWM || period_end)
                    compare_active_reg[gi] <= compare_value_reg[gi];
            end

            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    compare_inhibit_reg[gi] <= 1'b0;
                else if (bus.wr && bus.addr == A_HI)
                    compare_inhibit_reg[gi] <= 1'b1;
                else if (bus.wr && bus.addr == A_LO)
                    compare_inhibit_reg[gi] <= 1'b0;
            end

            // no hw compare flags in pwm, flag one not in one pulse
            assign set_cmp = match[gi] && (mode == TCP_MODE_CMP || (mode == TCP_MODE_PULSE && gi == 1));

            // set wins over clear
            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    compare_match_flag[gi] <= 1'b0;
                else if (set_cmp)
                    compare_match_flag[gi] <= 1'b1;
                else if (lo_access[gi] && flag_armed_cmp_reg[gi])
                    compare_match_flag[gi] <= 1'b0;
            end

            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    flag_armed_cmp_reg[gi] <= 1'b0;
                else if (status_read && compare_match_flag[gi])
                    flag_armed_cmp_reg[gi] <= 1'b1;
                else if (lo_access[gi] || !compare_match_flag[gi])
                    flag_armed_cmp_reg[gi] <= 1'b0;
            end

            // capture one only in compare mode; pulse trigger and pwm end also set it
            if (gi == 0)
            begin : g_c1
                assign set_cap = (mode == TCP_MODE_CMP && cap_edge[0] && !capture_inhibit_reg[0])
                                 || trig_pulse || period_end;
            end
            else
            begin : g_c2
                assign set_cap = cap_edge[1] && !capture_inhibit_reg[1];
            end

            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    capture_flag[gi] <= 1'b0;
                else if (set_cap)
                    capture_flag[gi] <= 1'b1;
                else if (cap_lo_access[gi] && flag_armed_cap_reg[gi])
                    capture_flag[gi] <= 1'b0;
            end

            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    flag_armed_cap_reg[gi] <= 1'b0;
                else if (status_read && capture_flag[gi])
                    flag_armed_cap_reg[gi] <= 1'b1;
                else if (cap_lo_access[gi] || !capture_flag[gi])
                    flag_armed_cap_reg[gi] <= 1'b0;
            end

            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    capture_value_reg[gi] <= 16'h0000;
                else if (gi == 0 && trig_pulse)
                    capture_value_reg[gi] <= `TCP_CAP_PULSE;
                else if (set_cap && !(gi == 0 && period_end))
                    capture_value_reg[gi] <= counter_reg;
            end

            // high byte read freezes the low byte and blocks capture till low read
            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    capture_inhibit_reg[gi] <= 1'b0;
                else if (bus.rd && bus.addr == (gi ? `TCP_A_CAP2_HI : `TCP_A_CAP1_HI))
                    capture_inhibit_reg[gi] <= 1'b1;
                else if (cap_lo_access[gi])
                    capture_inhibit_reg[gi] <= 1'b0;
            end

            always_ff @(posedge clock)
            begin
                if (!rst_n)
                    cap_lo_latch_reg[gi] <= 8'h00;
                else if (!capture_inhibit_reg[gi])
                    cap_lo_latch_reg[gi] <= capture_value_reg[gi][7:0];
            end
        end
    endgenerate

    // pin latches low in reset
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            pin_reg <= 2'b00;
        else
        begin
            unique case (mode)
                TCP_MODE_CMP:
                begin
                    if (match[0])
                        pin_reg[0] <= timer_control_one[`TCP_B_LVL1];
                    else if (timer_control_one[`TCP_B_FORCE1])
                        pin_reg[0] <= timer_control_one[`TCP_B_LVL1];
                    if (match[1])
                        pin_reg[1] <= timer_control_one[`TCP_B_LVL2];
                    else if (timer_control_one[`TCP_B_FORCE2])
                        pin_reg[1] <= timer_control_one[`TCP_B_LVL2];
                end
                TCP_MODE_PULSE: // force ignored, pin two idle
                begin
                    if (trig_pulse)
                        pin_reg[0] <= timer_control_one[`TCP_B_LVL2];
                    else if (match[0])
                        pin_reg[0] <= timer_control_one[`TCP_B_LVL1];
                end
                TCP_MODE_PWM:
                begin
                    if (match[1])
                        pin_reg[0] <= timer_control_one[`TCP_B_LVL2];
                    else if (match[0])
                        pin_reg[0] <= timer_control_one[`TCP_B_LVL1];
                end
                default:
                    pin_reg <= pin_reg;
            endcase
        end
    end

    // disabled pin stays general i/o
    assign compare_output_pin = pin_reg & compare_pin_enable;
    assign compare_pin_enable[0] = timer_control_two[`TCP_B_PIN_EN1];
    assign compare_pin_enable[1] = timer_control_two[`TCP_B_PIN_EN2] && (mode == TCP_MODE_CMP);

    // shared interrupt
    assign timer_irq = !cpu_irq_mask &&
                       ((timer_control_one[`TCP_B_CMP_IE] && |compare_match_flag) ||
                        (timer_control_one[`TCP_B_CAP_IE] && |capture_flag));

    always_comb
    begin
        rdata_next = 8'h00;
        unique case (bus.addr)
            `TCP_A_CTRL_ONE: rdata_next = timer_control_one;
            `TCP_A_CTRL_TWO: rdata_next = timer_control_two;
            `TCP_A_STATUS:   rdata_next = {capture_flag[0], compare_match_flag[0], 1'b0,
                                           capture_flag[1], compare_match_flag[1], 3'b000};
            `TCP_A_CMP1_HI:  rdata_next = compare_value_reg[0][15:8];
            `TCP_A_CMP1_LO:  rdata_next = compare_value_reg[0][7:0];
            `TCP_A_CMP2_HI:  rdata_next = compare_value_reg[1][15:8];
            `TCP_A_CMP2_LO:  rdata_next = compare_value_reg[1][7:0];
            `TCP_A_CAP1_HI:  rdata_next = capture_value_reg[0][15:8];
            `TCP_A_CAP1_LO:  rdata_next = cap_lo_latch_reg[0];
            `TCP_A_CAP2_HI:  rdata_next = capture_value_reg[1][15:8];
            `TCP_A_CAP2_LO:  rdata_next = cap_lo_latch_reg[1];
            `TCP_A_CNT_HI:   rdata_next = counter_reg[15:8];
            `TCP_A_CNT_LO:   rdata_next = counter_reg[7:0];
            default:         rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            rdata <= 8'h00;
        else if (bus.rd)
            rdata <= rdata_next;
        else
            rdata <= 8'h00;
    end
endmodule : tcp_timer
`default_nettype wire

// ===== shared/tcp_params.svh
/*
 timer constants and rule summary.
 assumes inclusion by bare name.
*/
// What this block does
// - a match sets its flag and drives its level on an enabled pin.
// - compare output pin latches are held low during reset.
// - compare interrupt needs compare interrupt enable and a clear cpu mask bit.
// - flag clears after a status read while set, then a low byte access.
// - a high byte write inhibits compare until the low byte write.
// - a disabled pin stays general i/o, but a match may still interrupt.
// - flag and pin update in the tick where counter equals compare value.
// - a force bit copies its level to an enabled pin, no flag or irq.
// - force bits are ignored in one pulse and pwm modes.
// - one pulse mode is selected by its bit in control two.
// - a trigger edge loads FFFC, drives level two, sets capture flag one, captures FFFD.
// - capture flag one from the trigger interrupts when capture interrupt is enabled.
// - in one pulse mode a compare one match drives level one, ending the pulse.
// - one pulse mode never sets compare flag one; compare two flags only.
// - one pulse mode reserves compare one and level two.
// - with both mode bits set only pwm mode operates.
// - in pulse modes capture one does not capture; capture two still works.
// - pwm compare values are double buffered until the period end.
// - in pwm mode pin one takes level one on match one, level two on match two.
// - in pwm mode the compare two match reloads the counter with FFFC.
// - pwm sets no compare flags; compare two match sets capture flag one.
// - reset loads each compare register with 8000.
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH
`define TCP_ADDR_W        4
`define TCP_A_CTRL_ONE    4'h0
`define TCP_A_CTRL_TWO    4'h1
`define TCP_A_STATUS      4'h2
`define TCP_A_CMP1_HI     4'h3
`define TCP_A_CMP1_LO     4'h4
`define TCP_A_CMP2_HI     4'h5
`define TCP_A_CMP2_LO     4'h6
`define TCP_A_CAP1_HI     4'h7
`define TCP_A_CAP1_LO     4'h8
`define TCP_A_CAP2_HI     4'h9
`define TCP_A_CAP2_LO     4'hA
`define TCP_A_CNT_HI      4'hB
`define TCP_A_CNT_LO      4'hC
`define TCP_CMP_RESET     16'h8000
`define TCP_CNT_RELOAD    16'hFFFC
`define TCP_CAP_PULSE     16'hFFFD
`define TCP_CTRL_RESET    8'h00
// control one bit positions
`define TCP_B_CAP_IE      7
`define TCP_B_CMP_IE      6
`define TCP_B_FORCE2      4
`define TCP_B_FORCE1      3
`define TCP_B_LVL2        2
`define TCP_B_EDGE1       1
`define TCP_B_LVL1        0
// control two bit positions
`define TCP_B_PIN_EN1     7
`define TCP_B_PIN_EN2     6
`define TCP_B_PULSE       5
`define TCP_B_PWM         4
`define TCP_B_CLK_HI      3
`define TCP_B_CLK_LO      2
`define TCP_B_EDGE2       1
`define TCP_B_EXT_EDGE    0
// status bit positions
`define TCP_B_CAPF1       7
`define TCP_B_CMPF1       6
`define TCP_B_CAPF2       4
`define TCP_B_CMPF2       3
`endif

// ===== shared/tcp_pkg.sv
/*
 types for the compare timer block.
 assumes tcp_params.svh on the include path.
*/
`include "tcp_params.svh"
package tcp_pkg;
    typedef enum logic [1:0]
    {
        TCP_MODE_CMP   = 2'b00,
        TCP_MODE_PULSE = 2'b01,
        TCP_MODE_PWM   = 2'b11
    } tcp_mode_e;
    typedef struct packed
    {
        logic [`TCP_ADDR_W-1:0] addr;
        logic [7:0]             wdata;
        logic                   wr;
        logic                   rd;
    } tcp_bus_s;
endpackage : tcp_pkg

// ===== logic/tcp_tick.sv
/*
 timer tick generator: divides by 2, 4, 8 or follows an external clock edge.
 assumes ext_clk already synchronised to clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"
module tcp_tick
    import tcp_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic [1:0] clk_sel,
    input  wire logic       ext_edge_rise,
    input  wire logic       ext_clk,
    output logic            tick
);
    logic [2:0] div_reg;
    logic       ext_prev_reg;
    logic       ext_hit;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            div_reg <= 3'h0;
        else
            div_reg <= div_reg + 3'h1;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ext_prev_reg <= 1'b0;
        else
            ext_prev_reg <= ext_clk;
    end

    assign ext_hit = ext_edge_rise ? (ext_clk & ~ext_prev_reg) : (~ext_clk & ext_prev_reg);

    always_comb
    begin
        unique case (clk_sel)
            2'b00: tick = (div_reg[1:0] == 2'h3);
            2'b01: tick = (div_reg == 3'h7);
            2'b10: tick = div_reg[0];
            2'b11: tick = ext_hit;
        endcase
    end
endmodule : tcp_tick
`default_nettype wire

// ===== test/tcp_timer_sva.sv
/*
 port assertions for tcp_timer.
 assumes the bind below.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"
module tcp_timer_sva
    import tcp_pkg::*;
(
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire logic [`TCP_ADDR_W-1:0] addr,
    input wire logic [7:0]             wdata,
    input wire logic                   wr,
    input wire logic                   rd,
    input wire logic [7:0]             rdata,
    input wire logic                   cpu_irq_mask,
    input wire logic [1:0]             compare_output_pin,
    input wire logic [1:0]             compare_pin_enable,
    input wire logic                   timer_irq
);
    logic [7:0] ctl_one_reg;
    logic [7:0] ctl_two_reg;
    logic       cmp_mode;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ctl_one_reg <= 8'h00;
            ctl_two_reg <= 8'h00;
        end
        else if (wr && addr == `TCP_A_CTRL_ONE)
            ctl_one_reg <= wdata;
        else if (wr && addr == `TCP_A_CTRL_TWO)
            ctl_two_reg <= wdata;
    end
    assign cmp_mode = !ctl_two_reg[`TCP_B_PULSE] && !ctl_two_reg[`TCP_B_PWM];
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    reset_low_a: assert property (disable iff (1'b0) !rst_n |=> compare_output_pin == 2'h0 && rdata == 8'h00)
        else $error("pins or read data not low after reset");
    pin_masked_a: assert property ((compare_output_pin & ~compare_pin_enable) == 2'h0)
        else $error("disabled pin shows a level");
    enable_one_a: assert property (compare_pin_enable[0] == ctl_two_reg[`TCP_B_PIN_EN1])
        else $error("pin one enable differs from control");
    pin_two_off_a: assert property (!cmp_mode |-> !compare_pin_enable[1])
        else $error("pin two driven in a pulse mode");
    irq_masked_a: assert property (cpu_irq_mask |-> !timer_irq)
        else $error("interrupt while masked");
    irq_cause_a: assert property ($rose(timer_irq) |-> ctl_one_reg[`TCP_B_CAP_IE] || ctl_one_reg[`TCP_B_CMP_IE])
        else $error("interrupt without an enable");
    force_copy_a: assert property ((cmp_mode && ctl_one_reg[`TCP_B_FORCE1] && ctl_two_reg[`TCP_B_PIN_EN1]
        && $stable(ctl_one_reg))[*2] |-> compare_output_pin[0] == ctl_one_reg[`TCP_B_LVL1])
        else $error("forced level not on pin one");
    read_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside the answer cycle");
endmodule : tcp_timer_sva
bind tcp_timer tcp_timer_sva u_sva
(
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cpu_irq_mask(cpu_irq_mask), .compare_output_pin(compare_output_pin),
    .compare_pin_enable(compare_pin_enable), .timer_irq(timer_irq)
);
`default_nettype wire

// ===== test/tcp_pin_model.sv
/*
 far-side pins: capture pulses and external clock.
 assumes one-cycle fire requests.
*/
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_model
#(
    parameter int HOLD = 4
)
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic fire_one,
    input  wire logic fire_two,
    output logic      capture_input_one,
    output logic      capture_input_two,
    output logic      ext_clk_pin
);
    logic [7:0] one_left_reg;
    logic [7:0] two_left_reg;
    logic [2:0] div_reg;
    // pulse outlasts the two-flop synchroniser so both edges are seen
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            one_left_reg <= 8'h00;
            two_left_reg <= 8'h00;
        end
        else
        begin
            one_left_reg <= fire_one ? 8'(HOLD) : one_left_reg - 8'(one_left_reg != 8'h00);
            two_left_reg <= fire_two ? 8'(HOLD) : two_left_reg - 8'(two_left_reg != 8'h00);
        end
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            div_reg <= 3'h0;
        else
            div_reg <= div_reg + 3'h1;
    end
    assign capture_input_one = one_left_reg != 8'h00;
    assign capture_input_two = two_left_reg != 8'h00;
    assign ext_clk_pin       = div_reg[2];
endmodule : tcp_pin_model
`default_nettype wire

// ===== test/tcp_timer_tb.sv
/*
 bench for tcp_timer.
 assumes the pin model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"
module tcp_timer_tb
    import tcp_pkg::*;
;
    logic       clock;
    logic       rst_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       cpu_irq_mask;
    logic       cap_one;
    logic       cap_two;
    logic       ext_clk;
    logic [1:0] pin;
    logic [1:0] pen;
    logic       irq;
    logic       fire_one;
    logic       fire_two;
    logic [7:0] val;
    logic [7:0] v;
    int         n;
    int         errors;
    int         compares;
    tcp_timer DUT
    (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cpu_irq_mask(cpu_irq_mask), .capture_input_one(cap_one), .capture_input_two(cap_two),
        .ext_clk_pin(ext_clk), .compare_output_pin(pin), .compare_pin_enable(pen), .timer_irq(irq)
    );
    tcp_pin_model u_pins
    (
        .clock(clock), .rst_n(rst_n), .fire_one(fire_one), .fire_two(fire_two),
        .capture_input_one(cap_one), .capture_input_two(cap_two), .ext_clk_pin(ext_clk)
    );
    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task expect_reg(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd_reg(a, d);
        check(d, exp);
    endtask : expect_reg
    task wait_pin(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (pin[0] !== lvl)
        begin
            @(posedge clock);
            #1 cnt++;
            if (cnt > lim)
            begin
                check(pin[0], lvl);
                end_sim;
            end
        end
    endtask : wait_pin
    function int cycles(input int from_v, input int to_v);
        return 2 * ((to_v - from_v) & 16'hFFFF);
    endfunction : cycles
    task near(input int seen, input int exp);
        check(seen >= exp - 3 && seen <= exp + 3, 16'h0001);
    endtask : near
    task strobe(input int which);
        @(posedge clock);
        if (which == 1) fire_one <= 1'b1; else fire_two <= 1'b1;
        @(posedge clock);
        fire_one <= 1'b0;
        fire_two <= 1'b0;
    endtask : strobe
    initial
    begin
        errors = 0; compares = 0; rst_n = 1'b0; addr = 4'h0; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
        cpu_irq_mask = 1'b0; fire_one = 1'b0; fire_two = 1'b0;
        void'($urandom(32'h5f085dd2));
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1 check({pen, pin}, 4'h0);
        expect_reg(`TCP_A_CMP1_HI, 8'h80);
        expect_reg(`TCP_A_CMP1_LO, 8'h00);
        expect_reg(`TCP_A_CMP2_HI, 8'h80);
        expect_reg(`TCP_A_CMP2_LO, 8'h00);
        $display("reset test done");
        val = 8'h02 + 8'($urandom % 6);
        wr_reg(`TCP_A_CTRL_TWO, 8'h88);
        wr_reg(`TCP_A_CTRL_ONE, 8'h41);
        wr_reg(`TCP_A_CMP1_HI, 8'h00);
        wr_reg(`TCP_A_CNT_LO, 8'h00);
        wr_reg(`TCP_A_CMP1_LO, val);
        wait_pin(1'b1, 200, n);
        near(n, cycles(`TCP_CNT_RELOAD, val) - 2);
        check(irq, 1'b1);
        expect_reg(`TCP_A_STATUS, 8'h40);
        @(posedge clock);
        cpu_irq_mask <= 1'b1;
        @(posedge clock);
        #1 check(irq, 1'b0);
        cpu_irq_mask <= 1'b0;
        wr_reg(`TCP_A_CMP1_LO, val);
        expect_reg(`TCP_A_STATUS, 8'h00);
        $display("compare test done");
        wr_reg(`TCP_A_CMP1_HI, 8'h00);
        wr_reg(`TCP_A_CNT_LO, 8'h00);
        repeat (40) @(posedge clock);
        expect_reg(`TCP_A_STATUS, 8'h00);
        wr_reg(`TCP_A_CMP1_LO, val);
        wr_reg(`TCP_A_CTRL_TWO, 8'h08);
        wr_reg(`TCP_A_CNT_LO, 8'h00);
        repeat (cycles(`TCP_CNT_RELOAD, val) + 8) @(posedge clock);
        #1 check({pen[0], irq}, 2'h1);
        expect_reg(`TCP_A_STATUS, 8'h40);
        wr_reg(`TCP_A_CMP1_LO, val);
        $display("inhibit test done");
        wr_reg(`TCP_A_CTRL_ONE, 8'h00);
        wr_reg(`TCP_A_CTRL_TWO, 8'h88);
        wr_reg(`TCP_A_CTRL_ONE, 8'h08);
        repeat (3) @(posedge clock);
        #1 check(pin[0], 1'b0);
        wr_reg(`TCP_A_CTRL_ONE, 8'h09);
        repeat (3) @(posedge clock);
        #1 check(pin[0], 1'b1);
        expect_reg(`TCP_A_STATUS, 8'h00);
        $display("force test done");
        wr_reg(`TCP_A_CTRL_TWO, 8'hA8);
        wr_reg(`TCP_A_CTRL_ONE, 8'h8E);
        wr_reg(`TCP_A_CMP1_HI, 8'h00);
        wr_reg(`TCP_A_CMP1_LO, 8'h04);
        wr_reg(`TCP_A_CNT_LO, 8'h00);
        wait_pin(1'b0, 60, n);
        check(pin[0], 1'b0);
        strobe(1);
        wait_pin(1'b1, 20, n);
        check(irq, 1'b1);
        wait_pin(1'b0, 60, n);
        near(n, cycles(`TCP_CNT_RELOAD, 16'h0004));
        expect_reg(`TCP_A_STATUS, 8'h80);
        expect_reg(`TCP_A_CAP1_HI, 8'hFF);
        expect_reg(`TCP_A_CAP1_LO, 8'hFD);
        $display("one pulse test done");
        wr_reg(`TCP_A_CMP2_HI, 8'h00);
        wr_reg(`TCP_A_CMP1_HI, 8'h00);
        rd_reg(`TCP_A_STATUS, v);
        wr_reg(`TCP_A_CMP2_LO, 8'h30);
        wr_reg(`TCP_A_CMP1_LO, 8'h20);
        wr_reg(`TCP_A_CTRL_ONE, 8'h84);
        wr_reg(`TCP_A_CTRL_TWO, 8'hB8);
        wait_pin(1'b1, 70000, n);
        wait_pin(1'b0, 200, n);
        near(n, cycles(`TCP_CNT_RELOAD, 16'h0020));
        wait_pin(1'b1, 200, n);
        near(n, cycles(16'h0020, 16'h0030));
        strobe(2);
        repeat (12) @(posedge clock);
        expect_reg(`TCP_A_STATUS, 8'h90);
        check(irq, 1'b1);
        $display("pwm test done");
        end_sim;
    end
endmodule : tcp_timer_tb
`default_nettype wire
